// ### core/fmpm_bg_if.sv
// Signals between the register bank and the background crossing monitor
`timescale 1ns/1ps
`default_nettype none
interface fmpm_bg_if;
	import fmpm_pkg::*;

	logic                              sample_valid;
	logic                              subtract_cycle;
	logic                              restart;
	logic [THRESH_W-1:0]               threshold;
	logic [1:0]                        count_select;
	logic [NUM_CH-1:0][THRESH_W-1:0]   adc_result;
	logic [NUM_CH-1:0]                 flag_set;

	modport ctrl (
		output sample_valid,
		output subtract_cycle,
		output restart,
		output threshold,
		output count_select,
		output adc_result,
		input  flag_set
	);

	modport mon (
		input  sample_valid,
		input  subtract_cycle,
		input  restart,
		input  threshold,
		input  count_select,
		input  adc_result,
		output flag_set
	);
endinterface : fmpm_bg_if
`default_nettype wire

// ### core/fmpm_bg_monitor.sv
// Per-channel background crossing counters for slot B
`timescale 1ns/1ps
`default_nettype none
module fmpm_bg_monitor
	import fmpm_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_rstn,
	fmpm_bg_if.mon     bg
);

	typedef struct packed {
		logic [NUM_CH-1:0][CNT_W-1:0] cnt;
		logic [NUM_CH-1:0]            fired;
		logic [NUM_CH-1:0]            flag_set;
	} fmpm_mon_state_t;

	fmpm_mon_state_t   state;
	fmpm_mon_state_t   next_state;
	logic [NUM_CH-1:0] exceed;
	logic [CNT_W-1:0]  target;

	// Strictly greater than; equal does not count
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_cmp
			assign exceed[g] = bg.sample_valid && bg.subtract_cycle
				&& (bg.adc_result[g] > bg.threshold); // RL1
		end
	endgenerate

	always_comb
	begin
		case (bg.count_select) // RL13
			2'h1:    target = EXCEED_CNT_1;
			2'h2:    target = EXCEED_CNT_2;
			2'h3:    target = EXCEED_CNT_3;
			default: target = '0;
		endcase
	end

	always_comb
	begin
		next_state          = state;
		next_state.flag_set = '0;
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (bg.restart)
			begin
				next_state.cnt[i]   = '0;
				next_state.fired[i] = 1'b0;
			end
			else if (exceed[i] && state.cnt[i] != EXCEED_CNT_3)
			begin
				// Saturates at the largest target
				next_state.cnt[i] = state.cnt[i] + CNT_W'(1); // RL1
				if (target != '0 && (state.cnt[i] + CNT_W'(1)) == target && !state.fired[i])
				begin
					next_state.flag_set[i] = 1'b1; // RL13
					next_state.fired[i]    = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			state <= '0;
		else
			state <= next_state;
	end

	assign bg.flag_set = state.flag_set;

endmodule : fmpm_bg_monitor
`default_nettype wire

// ### core/fmpm_config.sv
// Float mode LED, pulse math and background threshold register bank
// Summary of operation
// RL1 - Slot B subtract cycles count ADC results above the 14-bit threshold.
// RL2 - Slot A LED choice: 0 none, 1..3 select LED one to three.
// RL3 - Slot B LED choice: 0 none, 1..3 select LED one to three.
// RL4 - Slot A pulse width is 5 bits in microseconds, reset 3.
// RL5 - Slot B pulse width is 5 bits in microseconds, reset 3.
// RL6 - Slot A delay to first pulse is 8 bits, reset 0x20.
// RL7 - Slot B delay to first pulse is 8 bits, reset 0x20.
// RL8 - Slot B signs of samples three and four per four-pulse group.
// RL9 - Slot A signs of samples three and four, repeated every group.
// RL10 - Slot B signs of samples one and two per four-pulse group.
// RL11 - Slot A signs of samples one and two, every group of four.
// RL12 - Integrator-buffer bit makes the integrator a buffer in TIA mode.
// RL13 - Count select sets flag after 1, 4, 16 crossings; 0 never.
// RL14 - Background status bits clear when their register is read.
// RL15 - Float mode active only when the enable field equals 3.
// RL16 - Software writes zero to reserved bits and programs before enabling.
`timescale 1ns/1ps
`default_nettype none
module fmpm_config
	import fmpm_pkg::*;
(
	input  wire logic                              i_clk,
	input  wire logic                              i_rstn,
	// Register port
	input  wire logic [ADDR_W-1:0]                 i_reg_addr,
	input  wire logic [DATA_W-1:0]                 i_reg_wdata,
	input  wire logic                              i_reg_wr,
	input  wire logic                              i_reg_rd,
	output logic      [DATA_W-1:0]                 o_reg_rdata,
	// Sequencer side
	input  wire logic                              i_slot_b_start,
	input  wire logic                              i_slot_b_sample_valid,
	input  wire logic [1:0]                        i_slot_b_pulse_index,
	input  wire logic [NUM_CH-1:0][THRESH_W-1:0]   i_slot_b_adc_result,
	input  wire logic [1:0]                        i_slot_a_pulse_index,
	input  wire logic                              i_tia_mode,
	output logic                                   o_slot_a_float_active,
	output logic                                   o_slot_b_float_active,
	output logic      [2:0]                        o_slot_a_led_select,
	output logic      [2:0]                        o_slot_b_led_select,
	output logic      [PW_CYC_W-1:0]               o_slot_a_pulse_cycles,
	output logic      [PW_CYC_W-1:0]               o_slot_b_pulse_cycles,
	output logic      [FIRST_DELAY_W-1:0]          o_slot_a_first_pulse_delay,
	output logic      [FIRST_DELAY_W-1:0]          o_slot_b_first_pulse_delay,
	output logic                                   o_slot_a_subtract,
	output logic                                   o_slot_b_subtract,
	output logic                                   o_integrator_buffer,
	output logic      [NUM_CH-1:0]                 o_slot_b_background_flags
);

	typedef struct packed {
		logic [1:0]                 slot_a_float_led_choice;
		logic [PULSE_WIDTH_W-1:0]   slot_a_float_pulse_width;
		logic [FIRST_DELAY_W-1:0]   slot_a_float_first_pulse_delay;
		logic [1:0]                 slot_b_float_led_choice;
		logic [PULSE_WIDTH_W-1:0]   slot_b_float_pulse_width;
		logic [FIRST_DELAY_W-1:0]   slot_b_float_first_pulse_delay;
		logic [1:0]                 slot_b_pair_two_sign_control;
		logic [1:0]                 slot_a_pair_two_sign_control;
		logic                       integrator_buffer_enable;
		logic [1:0]                 slot_b_pair_one_sign_control;
		logic [1:0]                 slot_a_pair_one_sign_control;
		logic [1:0]                 slot_b_exceed_count_select;
		logic [THRESH_W-1:0]        slot_b_background_threshold;
		logic [1:0]                 slot_a_float_enable;
		logic [1:0]                 slot_b_float_enable;
		logic [NUM_CH-1:0]          slot_b_background_flags;
		logic [DATA_W-1:0]          rdata;
		logic                       a_active;
		logic                       b_active;
		logic [2:0]                 a_led;
		logic [2:0]                 b_led;
		logic [PW_CYC_W-1:0]        a_cycles;
		logic [PW_CYC_W-1:0]        b_cycles;
		logic                       a_sub;
		logic                       b_sub;
		logic                       int_buf;
	} fmpm_cfg_state_t;

	localparam fmpm_cfg_state_t STATE_RST = '{
		slot_a_float_led_choice:        LED_CHOICE_RST,
		slot_a_float_pulse_width:       PULSE_WIDTH_RST,
		slot_a_float_first_pulse_delay: FIRST_DELAY_RST,
		slot_b_float_led_choice:        LED_CHOICE_RST,
		slot_b_float_pulse_width:       PULSE_WIDTH_RST,
		slot_b_float_first_pulse_delay: FIRST_DELAY_RST,
		slot_b_pair_two_sign_control:   SIGN_CTRL_RST,
		slot_a_pair_two_sign_control:   SIGN_CTRL_RST,
		integrator_buffer_enable:       1'b0,
		slot_b_pair_one_sign_control:   SIGN_CTRL_RST,
		slot_a_pair_one_sign_control:   SIGN_CTRL_RST,
		slot_b_exceed_count_select:     COUNT_SEL_RST,
		slot_b_background_threshold:    THRESH_RST,
		slot_a_float_enable:            FLT_EN_RST,
		slot_b_float_enable:            FLT_EN_RST,
		slot_b_background_flags:        '0,
		rdata:                          '0,
		a_active:                       1'b0,
		b_active:                       1'b0,
		a_led:                          '0,
		b_led:                          '0,
		a_cycles:                       PW_CYC_W'(PULSE_WIDTH_RST) * PW_CYC_W'(PULSE_UNIT_CYCLES),
		b_cycles:                       PW_CYC_W'(PULSE_WIDTH_RST) * PW_CYC_W'(PULSE_UNIT_CYCLES),
		a_sub:                          1'b0,
		b_sub:                          1'b0,
		int_buf:                        1'b0
	};

	fmpm_cfg_state_t state;
	fmpm_cfg_state_t next_state;
	logic [3:0]      a_sign_mask;
	logic [3:0]      b_sign_mask;

	fmpm_bg_if bg_link ();

	// Bit k set means pulse k of each group of four is subtracted
	function automatic logic [3:0] sign_mask(input logic [1:0] pair_one, input logic [1:0] pair_two);
		sign_mask = {pair_two[0], pair_two[1], pair_one[0], pair_one[1]};
	endfunction : sign_mask

	// One-hot LED drive; code 0 leaves every LED dark
	function automatic logic [2:0] led_decode(input logic [1:0] choice);
		case (choice)
			2'h1:    led_decode = 3'h1;
			2'h2:    led_decode = 3'h2;
			2'h3:    led_decode = 3'h4;
			default: led_decode = 3'h0;
		endcase
	endfunction : led_decode

	function automatic logic [PW_CYC_W-1:0] width_cycles(input logic [PULSE_WIDTH_W-1:0] width);
		width_cycles = PW_CYC_W'(width) * PW_CYC_W'(PULSE_UNIT_CYCLES);
	endfunction : width_cycles

	assign a_sign_mask = sign_mask(state.slot_a_pair_one_sign_control,
		state.slot_a_pair_two_sign_control); // RL9 RL11
	assign b_sign_mask = sign_mask(state.slot_b_pair_one_sign_control,
		state.slot_b_pair_two_sign_control); // RL8 RL10

	// Only the low two index bits matter, so the pattern repeats every four pulses
	assign bg_link.sample_valid   = i_slot_b_sample_valid;
	assign bg_link.subtract_cycle = state.b_active && b_sign_mask[i_slot_b_pulse_index]; // RL1
	assign bg_link.restart        = i_slot_b_start;
	assign bg_link.threshold      = state.slot_b_background_threshold;
	assign bg_link.count_select   = state.slot_b_exceed_count_select;
	assign bg_link.adc_result     = i_slot_b_adc_result;

	fmpm_bg_monitor u_bg_monitor (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.bg     (bg_link.mon)
	);

	always_comb
	begin
		next_state = state;

		if (i_reg_wr)
		begin
			// Reserved bits are dropped on write and read back as zero
			case (i_reg_addr)
				ADDR_LED_SETUP_A:
				begin
					next_state.slot_a_float_led_choice        = i_reg_wdata[LED_CHOICE_LSB +: 2];
					next_state.slot_a_float_pulse_width       = i_reg_wdata[PULSE_WIDTH_LSB +: PULSE_WIDTH_W];
					next_state.slot_a_float_first_pulse_delay = i_reg_wdata[FIRST_DELAY_LSB +: FIRST_DELAY_W];
				end
				ADDR_LED_SETUP_B:
				begin
					next_state.slot_b_float_led_choice        = i_reg_wdata[LED_CHOICE_LSB +: 2];
					next_state.slot_b_float_pulse_width       = i_reg_wdata[PULSE_WIDTH_LSB +: PULSE_WIDTH_W];
					next_state.slot_b_float_first_pulse_delay = i_reg_wdata[FIRST_DELAY_LSB +: FIRST_DELAY_W];
				end
				ADDR_MATH_CTRL:
				begin
					next_state.slot_b_pair_two_sign_control = i_reg_wdata[B_PAIR_TWO_LSB +: 2];
					next_state.slot_a_pair_two_sign_control = i_reg_wdata[A_PAIR_TWO_LSB +: 2];
					next_state.integrator_buffer_enable     = i_reg_wdata[INT_BUF_BIT];
					next_state.slot_b_pair_one_sign_control = i_reg_wdata[B_PAIR_ONE_LSB +: 2];
					next_state.slot_a_pair_one_sign_control = i_reg_wdata[A_PAIR_ONE_LSB +: 2];
				end
				ADDR_BG_CFG_B:
				begin
					next_state.slot_b_exceed_count_select  = i_reg_wdata[COUNT_SEL_LSB +: 2];
					next_state.slot_b_background_threshold = i_reg_wdata[THRESH_LSB +: THRESH_W];
				end
				ADDR_A_FLOAT_ON:
					next_state.slot_a_float_enable = i_reg_wdata[FLT_EN_LSB +: 2];
				ADDR_B_FLOAT_ON:
					next_state.slot_b_float_enable = i_reg_wdata[FLT_EN_LSB +: 2];
				default:
					next_state = state;
			endcase
		end

		if (i_reg_rd)
		begin
			case (i_reg_addr)
				ADDR_BG_STATUS:
				begin
					next_state.rdata = DATA_W'({state.slot_b_background_flags, 4'h0});
					next_state.slot_b_background_flags = '0; // RL14
				end
				ADDR_LED_SETUP_A:
					next_state.rdata = {state.slot_a_float_led_choice, 1'b0,
						state.slot_a_float_pulse_width, state.slot_a_float_first_pulse_delay};
				ADDR_LED_SETUP_B:
					next_state.rdata = {state.slot_b_float_led_choice, 1'b0,
						state.slot_b_float_pulse_width, state.slot_b_float_first_pulse_delay};
				ADDR_MATH_CTRL:
					next_state.rdata = {4'h0, state.slot_b_pair_two_sign_control,
						state.slot_a_pair_two_sign_control, state.integrator_buffer_enable,
						state.slot_b_pair_one_sign_control, 2'h0,
						state.slot_a_pair_one_sign_control, 1'b0};
				ADDR_BG_CFG_B:
					next_state.rdata = {state.slot_b_exceed_count_select, state.slot_b_background_threshold};
				ADDR_A_FLOAT_ON:
					next_state.rdata = DATA_W'({state.slot_a_float_enable, 13'h0000});
				ADDR_B_FLOAT_ON:
					next_state.rdata = DATA_W'({state.slot_b_float_enable, 13'h0000});
				default:
					next_state.rdata = '0;
			endcase
		end

		// A crossing in the clearing cycle survives the read
		next_state.slot_b_background_flags = next_state.slot_b_background_flags
			| bg_link.flag_set; // RL13 RL14

		// Codes 1 and 2 are reserved and behave as disabled
		next_state.a_active = (state.slot_a_float_enable == FLT_EN_ON); // RL15
		next_state.b_active = (state.slot_b_float_enable == FLT_EN_ON); // RL15
		next_state.a_led    = state.a_active ? led_decode(state.slot_a_float_led_choice) : 3'h0; // RL2
		next_state.b_led    = state.b_active ? led_decode(state.slot_b_float_led_choice) : 3'h0; // RL3
		next_state.a_cycles = width_cycles(state.slot_a_float_pulse_width); // RL4
		next_state.b_cycles = width_cycles(state.slot_b_float_pulse_width); // RL5
		next_state.a_sub    = state.a_active && a_sign_mask[i_slot_a_pulse_index]; // RL9 RL11
		next_state.b_sub    = state.b_active && b_sign_mask[i_slot_b_pulse_index]; // RL8 RL10
		next_state.int_buf  = state.integrator_buffer_enable && i_tia_mode; // RL12
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			state <= STATE_RST;
		else
			state <= next_state;
	end

	assign o_reg_rdata                = state.rdata;
	assign o_slot_a_float_active      = state.a_active;
	assign o_slot_b_float_active      = state.b_active;
	assign o_slot_a_led_select        = state.a_led;
	assign o_slot_b_led_select        = state.b_led;
	assign o_slot_a_pulse_cycles      = state.a_cycles;
	assign o_slot_b_pulse_cycles      = state.b_cycles;
	assign o_slot_a_first_pulse_delay = state.slot_a_float_first_pulse_delay; // RL6
	assign o_slot_b_first_pulse_delay = state.slot_b_float_first_pulse_delay; // RL7
	assign o_slot_a_subtract          = state.a_sub;
	assign o_slot_b_subtract          = state.b_sub;
	assign o_integrator_buffer        = state.int_buf;
	assign o_slot_b_background_flags  = state.slot_b_background_flags;

endmodule : fmpm_config
`default_nettype wire

// ### core/fmpm_pkg.sv
// Constants, register map and field layout of the float mode configuration bank
`default_nettype none
package fmpm_pkg;
	// Register port widths
	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 16;

	// Register offsets, as seen on the register port
	localparam logic [7:0]  ADDR_BG_STATUS    = 8'h04;
	localparam logic [7:0]  ADDR_BG_CFG_B     = 8'h1C;
	localparam logic [7:0]  ADDR_LED_SETUP_A  = 8'h3E;
	localparam logic [7:0]  ADDR_LED_SETUP_B  = 8'h3F;
	localparam logic [7:0]  ADDR_MATH_CTRL    = 8'h58;
	localparam logic [7:0]  ADDR_B_FLOAT_ON   = 8'h59;
	localparam logic [7:0]  ADDR_A_FLOAT_ON   = 8'h5E;

	// Field positions
	localparam int          LED_CHOICE_LSB    = 14;
	localparam int          PULSE_WIDTH_LSB   = 8;
	localparam int          FIRST_DELAY_LSB   = 0;
	localparam int          THRESH_LSB        = 0;
	localparam int          COUNT_SEL_LSB     = 14;
	localparam int          B_PAIR_TWO_LSB    = 10;
	localparam int          A_PAIR_TWO_LSB    = 8;
	localparam int          INT_BUF_BIT       = 7;
	localparam int          B_PAIR_ONE_LSB    = 5;
	localparam int          A_PAIR_ONE_LSB    = 1;
	localparam int          FLT_EN_LSB        = 13;
	localparam int          B_FLAGS_LSB       = 4;

	// Field widths
	localparam int          THRESH_W          = 14;
	localparam int          PULSE_WIDTH_W     = 5;
	localparam int          FIRST_DELAY_W     = 8;
	localparam int          NUM_CH            = 4;
	localparam int          CNT_W             = 5;
	localparam int          PW_CYC_W          = 11;

	// Reset values
	localparam logic [1:0]  LED_CHOICE_RST    = 2'h0;
	localparam logic [4:0]  PULSE_WIDTH_RST   = 5'h03;
	localparam logic [7:0]  FIRST_DELAY_RST   = 8'h20;
	localparam logic [13:0] THRESH_RST        = 14'h0000;
	localparam logic [1:0]  COUNT_SEL_RST     = 2'h0;
	localparam logic [1:0]  SIGN_CTRL_RST     = 2'h0;
	localparam logic [1:0]  FLT_EN_RST        = 2'h0;

	// Float enable code that turns float mode on
	localparam logic [1:0]  FLT_EN_ON         = 2'h3;

	// Crossing counts per count-select code
	localparam logic [4:0]  EXCEED_CNT_1      = 5'h01;
	localparam logic [4:0]  EXCEED_CNT_2      = 5'h04;
	localparam logic [4:0]  EXCEED_CNT_3      = 5'h10;

	// Pulse width unit and clock
	localparam int          PULSE_UNIT_NS     = 1000;
	localparam int          CLK_PERIOD_NS     = 25;
	localparam int          PULSE_UNIT_CYCLES = PULSE_UNIT_NS / CLK_PERIOD_NS;
endpackage : fmpm_pkg
`default_nettype wire

// ### dv/fmpm_config_chk.sv
// Concurrent checks on the ports of the float mode configuration bank
`timescale 1ns/1ps
`default_nettype none
module fmpm_config_chk
	import fmpm_pkg::*;
(
	input  wire logic                     i_clk,
	input  wire logic                     i_rstn,
	input  wire logic [ADDR_W-1:0]        i_reg_addr,
	input  wire logic [DATA_W-1:0]        i_reg_wdata,
	input  wire logic                     i_reg_wr,
	input  wire logic                     i_reg_rd,
	input  wire logic [DATA_W-1:0]        o_reg_rdata,
	input  wire logic                     i_slot_b_sample_valid,
	input  wire logic [1:0]               i_slot_b_pulse_index,
	input  wire logic                     i_tia_mode,
	input  wire logic                     o_slot_a_float_active,
	input  wire logic                     o_slot_b_float_active,
	input  wire logic [2:0]               o_slot_b_led_select,
	input  wire logic [PW_CYC_W-1:0]      o_slot_a_pulse_cycles,
	input  wire logic [FIRST_DELAY_W-1:0] o_slot_b_first_pulse_delay,
	input  wire logic                     o_slot_b_subtract,
	input  wire logic                     o_integrator_buffer,
	input  wire logic [NUM_CH-1:0]        o_slot_b_background_flags
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	logic [DATA_W-1:0] math_q;

	// Shadow of the sign controls, so subtract can be judged from the ports alone
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			math_q <= 16'h0000;
		else if (i_reg_wr && i_reg_addr == ADDR_MATH_CTRL)
			math_q <= i_reg_wdata;
	end

	function automatic logic [2:0] led_code(input logic [15:0] w);
		return (w[15:14] == 2'h0) ? 3'h0 : 3'(3'h1 << (w[15:14] - 2'h1));
	endfunction : led_code

	function automatic logic sign_b(input logic [15:0] m, input logic [1:0] i);
		return m[(i[1] ? 10 : 5) + (i[0] ? 0 : 1)];
	endfunction : sign_b

	sequence s_wr(logic [7:0] a);
		i_reg_wr && i_reg_addr == a;
	endsequence
	// A crossing one edge earlier would legally win over the clear
	sequence s_quiet_read;
		i_reg_rd && i_reg_addr == ADDR_BG_STATUS && !$past(i_slot_b_sample_valid) && !$past(i_slot_b_sample_valid, 2);
	endsequence
	sequence s_b_steady;
		$stable(o_slot_b_float_active) ##1 $stable(o_slot_b_float_active);
	endsequence

	float_on_b_a:
	assert property (s_wr(ADDR_B_FLOAT_ON) |-> ##2 o_slot_b_float_active == ((($past(i_reg_wdata, 2) >> FLT_EN_LSB) & 16'h3) == 16'h3))
		else $error("slot b float active wrong after enable write");
	float_on_a_a:
	assert property (s_wr(ADDR_A_FLOAT_ON) |-> ##2 o_slot_a_float_active == ((($past(i_reg_wdata, 2) >> FLT_EN_LSB) & 16'h3) == 16'h3))
		else $error("slot a float active wrong after enable write");
	width_a_a:
	assert property (s_wr(ADDR_LED_SETUP_A) |-> ##2
		o_slot_a_pulse_cycles == 11'((($past(i_reg_wdata, 2) >> PULSE_WIDTH_LSB) & 16'h1F) * PULSE_UNIT_CYCLES))
		else $error("slot a pulse cycles wrong after width write");
	delay_b_a:
	assert property (s_wr(ADDR_LED_SETUP_B) |-> ##2 o_slot_b_first_pulse_delay == 8'($past(i_reg_wdata, 2)))
		else $error("slot b first pulse delay wrong after write");
	led_b_a:
	assert property (s_wr(ADDR_LED_SETUP_B) |-> ##2
		o_slot_b_led_select == (o_slot_b_float_active ? led_code($past(i_reg_wdata, 2)) : 3'h0))
		else $error("slot b led select wrong after write");
	int_buf_a:
	assert property (s_wr(ADDR_MATH_CTRL) |-> ##2 o_integrator_buffer == ($past(i_reg_wdata[INT_BUF_BIT], 2) && $past(i_tia_mode)))
		else $error("integrator buffer wrong after control write");
	sub_sign_b_a:
	assert property (s_b_steady |-> o_slot_b_subtract == (o_slot_b_float_active && sign_b($past(math_q), $past(i_slot_b_pulse_index))))
		else $error("slot b subtract does not follow sign control");
	flag_clear_a:
	assert property (s_quiet_read |=> o_slot_b_background_flags == 4'h0 &&
		o_reg_rdata == {8'h00, $past(o_slot_b_background_flags), 4'h0})
		else $error("status read did not return and clear flags");
	flag_cause_a:
	assert property ((o_slot_b_background_flags & ~$past(o_slot_b_background_flags)) != 4'h0 |-> $past(i_slot_b_sample_valid, 2))
		else $error("flag rose without a sample two cycles before");
	flag_hold_a:
	assert property ((~o_slot_b_background_flags & $past(o_slot_b_background_flags)) != 4'h0 |->
		$past(i_reg_rd) && $past(i_reg_addr) == ADDR_BG_STATUS)
		else $error("flag fell without a status read");
endmodule : fmpm_config_chk

bind fmpm_config fmpm_config_chk chk_u (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_slot_b_sample_valid(i_slot_b_sample_valid),
	.i_slot_b_pulse_index(i_slot_b_pulse_index), .i_tia_mode(i_tia_mode), .o_slot_a_float_active(o_slot_a_float_active),
	.o_slot_b_float_active(o_slot_b_float_active), .o_slot_b_led_select(o_slot_b_led_select),
	.o_slot_a_pulse_cycles(o_slot_a_pulse_cycles), .o_slot_b_first_pulse_delay(o_slot_b_first_pulse_delay),
	.o_slot_b_subtract(o_slot_b_subtract), .o_integrator_buffer(o_integrator_buffer),
	.o_slot_b_background_flags(o_slot_b_background_flags));
`default_nettype wire

// ### dv/fmpm_host.sv
// Host model: register writes and reads on the bank's register port
`timescale 1ns/1ps
`default_nettype none
module fmpm_host
	import fmpm_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic [DATA_W-1:0] i_rdata,
	output logic      [ADDR_W-1:0] o_addr,
	output logic      [DATA_W-1:0] o_wdata,
	output logic                   o_wr,
	output logic                   o_rd
);
	initial
	begin
		o_addr = 8'h00;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// Data is inverted once taken, so the bank cannot lean on a stale bus
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask : rd
endmodule : fmpm_host
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the float mode configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb_top
	import fmpm_pkg::*;
;
	typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} fmpm_row_t;

	logic                            i_clk = 1'b0;
	logic                            i_rstn = 1'b0;
	logic [ADDR_W-1:0]               addr;
	logic [DATA_W-1:0]               wdata, rdata;
	logic                            wr, rd, b_start, b_valid, tia, a_act, b_act, a_sub, b_sub, ibuf;
	logic [1:0]                      a_idx, b_idx;
	logic [NUM_CH-1:0][THRESH_W-1:0] adc;
	logic [2:0]                      a_led, b_led;
	logic [PW_CYC_W-1:0]             a_cyc, b_cyc;
	logic [FIRST_DELAY_W-1:0]        a_dly, b_dly;
	logic [NUM_CH-1:0]               flags;
	int                              bad_count = 0;
	int                              checks_done = 0;
	int                              tgt [4] = '{16, 1, 4, 16};
	fmpm_row_t                       rows [15] = '{
		'{1'b0, 8'h3E, 16'h0000, 16'h0320}, '{1'b0, 8'h3F, 16'h0000, 16'h0320}, '{1'b0, 8'h58, 16'h0000, 16'h0000},
		'{1'b0, 8'h1C, 16'h0000, 16'h0000}, '{1'b0, 8'h59, 16'h0000, 16'h0000}, '{1'b0, 8'h5E, 16'h0000, 16'h0000},
		'{1'b0, 8'h04, 16'h0000, 16'h0000}, '{1'b1, 8'h3E, 16'hFFFF, 16'hDFFF}, '{1'b1, 8'h3F, 16'h5F81, 16'h5F81},
		'{1'b1, 8'h58, 16'hFFFF, 16'h0FE6}, '{1'b1, 8'h1C, 16'hFFFF, 16'hFFFF}, '{1'b1, 8'h59, 16'hFFFF, 16'h6000},
		'{1'b1, 8'h5E, 16'h7FFF, 16'h6000}, '{1'b1, 8'h04, 16'hFFFF, 16'h0000}, '{1'b1, 8'h10, 16'h1234, 16'h0000}};

	always #12.5 i_clk = ~i_clk;
	fmpm_host host_u (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	fmpm_config dut_u (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_slot_b_start(b_start), .i_slot_b_sample_valid(b_valid), .i_slot_b_pulse_index(b_idx),
		.i_slot_b_adc_result(adc), .i_slot_a_pulse_index(a_idx), .i_tia_mode(tia), .o_slot_a_float_active(a_act),
		.o_slot_b_float_active(b_act), .o_slot_a_led_select(a_led), .o_slot_b_led_select(b_led),
		.o_slot_a_pulse_cycles(a_cyc), .o_slot_b_pulse_cycles(b_cyc), .o_slot_a_first_pulse_delay(a_dly),
		.o_slot_b_first_pulse_delay(b_dly), .o_slot_a_subtract(a_sub), .o_slot_b_subtract(b_sub),
		.o_integrator_buffer(ibuf), .o_slot_b_background_flags(flags));

	task automatic results();
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask : idle

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		host_u.rd(a, v);
		`CHK("rdata", e, v)
	endtask : rchk

	// Channel 1 sits exactly on the threshold, so strict comparison is exercised
	task automatic smp(input logic [1:0] idx, input logic [13:0] v);
		@(posedge i_clk);
		b_valid <= 1'b1;
		b_idx <= idx;
		adc <= {v, v, v - 14'h1, v};
		@(posedge i_clk);
		b_valid <= 1'b0;
	endtask : smp

	initial
	begin
		#(25 * 20000);
		bad_count++;
		results();
	end

	initial
	begin
		{b_start, b_valid, tia, a_idx, b_idx} = '0;
		adc = '0;
		idle(12);
		i_rstn <= 1'b1;
		foreach (rows[i])
		begin
			if (rows[i].w)
				host_u.wr(rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		`CHK("cyc_a", 11'd1240, a_cyc)
		`CHK("cyc_b", 11'd1240, b_cyc)
		`CHK("dly_a", 8'hFF, a_dly)
		`CHK("dly_b", 8'h81, b_dly)
		for (int k = 0; k < 4; k++)
		begin
			host_u.wr(ADDR_B_FLOAT_ON, 16'(k) << 13);
			idle(2);
			`CHK("act_b", (k == 3), b_act)
		end
		for (int c = 0; c < 4; c++)
		begin
			host_u.wr(ADDR_LED_SETUP_B, {2'(c), 14'h0320});
			host_u.wr(ADDR_LED_SETUP_A, {2'(c), 14'h0320});
			idle(2);
			`CHK("led_b", (c == 0) ? 3'h0 : 3'h1 << (c - 1), b_led)
			`CHK("led_a", (c == 0) ? 3'h0 : 3'h1 << (c - 1), a_led)
		end
		host_u.wr(ADDR_A_FLOAT_ON, 16'h0000);
		idle(3);
		`CHK("act_a", 1'b0, a_act)
		`CHK("led_a_off", 3'h0, a_led)
		host_u.wr(ADDR_A_FLOAT_ON, 16'h6000);
		for (int m = 0; m < 4; m++)
		begin
			tia <= m[1];
			host_u.wr(ADDR_MATH_CTRL, 16'((m << 10) | (m << 8) | ((m & 1) << 7) | (m << 5) | (m << 1)));
			idle(2);
			`CHK("ibuf", 1'(m == 3), ibuf)
			for (int x = 0; x < 4; x++)
			begin
				a_idx <= 2'(x);
				b_idx <= 2'(x);
				idle(2);
				`CHK("sub_b", (x % 2) ? m[0] : m[1], b_sub)
				`CHK("sub_a", (x % 2) ? m[0] : m[1], a_sub)
			end
		end
		host_u.wr(ADDR_MATH_CTRL, 16'h0060);
		for (int s = 0; s < 4; s++)
		begin
			host_u.wr(ADDR_BG_CFG_B, {2'(s), 14'h3FFE});
			@(posedge i_clk);
			b_start <= 1'b1;
			@(posedge i_clk);
			b_start <= 1'b0;
			smp(2'h2, 14'h3FFF);
			for (int n = 1; n < tgt[s]; n++)
				smp(2'(n % 2), 14'h3FFF);
			idle(3);
			`CHK("flags_early", 4'h0, flags)
			smp(2'h0, 14'h3FFF);
			idle(3);
			`CHK("flags", (s == 0) ? 4'h0 : 4'hD, flags)
			rchk(ADDR_BG_STATUS, {8'h00, (s == 0) ? 4'h0 : 4'hD, 4'h0});
			`CHK("flags_clr", 4'h0, flags)
		end
		@(posedge i_clk);
		i_rstn <= 1'b0;
		idle(2);
		`CHK("rst_cyc", 11'd120, b_cyc)
		`CHK("rst_dly", 8'h20, a_dly)
		`CHK("rst_act", 1'b0, b_act)
		`CHK("rst_rdata", 16'h0000, rdata)
		i_rstn <= 1'b1;
		rchk(ADDR_MATH_CTRL, 16'h0000);
		rchk(ADDR_LED_SETUP_B, 16'h0320);
		results();
	end
endmodule : tb_top
`default_nettype wire
